// >>> bench/cre_cable_model.sv
// Purpose: cable with one echo per pair and crosstalk to the other pair
// Assumes: sample tracks the driver level in the same cycle
// Notes:   echo is half amplitude, crosstalk a quarter, four slots later
`timescale 1ns/100ps
module cre_cable_model
    import cre_pkg::*;
#(
    parameter int ECHO_DLY = 20
)
(
    input  wire logic                clock,    // engine clock
    input  wire logic                reset,    // async reset
    input  wire cre_pkg::cre_drive_t drive,    // driver controls
    output cre_pkg::cre_samples_t    samples   // converter samples
);
    // ==========================================================
    // launched level per pair and delay lines
    localparam int DEPTH = ECHO_DLY + 4;
    logic signed [7:0] pulse_v;
    logic signed [7:0] tx_out;
    logic signed [7:0] rx_out;
    logic signed [7:0] tx_line_r [DEPTH];
    logic signed [7:0] rx_line_r [DEPTH];

    always_comb begin
        pulse_v = 8'sd0;
        if (drive.ls_drive || drive.hs_drive) begin
            pulse_v = (drive.hs_drive && drive.hs_negative) ? -8'sd100 : 8'sd100;
        end
        tx_out          = drive.on_rx_pair ? 8'sd0 : pulse_v;
        rx_out          = drive.on_rx_pair ? pulse_v : 8'sd0;
        samples.tx_pair = tx_out + (tx_line_r[ECHO_DLY-1] >>> 1) + (rx_line_r[ECHO_DLY+3] >>> 2);
        samples.rx_pair = rx_out + (rx_line_r[ECHO_DLY-1] >>> 1) + (tx_line_r[ECHO_DLY+3] >>> 2);
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            for (int k = 0; k < DEPTH; k++) begin
                tx_line_r[k] <= 8'sd0;
                rx_line_r[k] <= 8'sd0;
            end
        end else begin
            tx_line_r[0] <= tx_out;
            rx_line_r[0] <= rx_out;
            for (int k = 1; k < DEPTH; k++) begin
                tx_line_r[k] <= tx_line_r[k-1];
                rx_line_r[k] <= rx_line_r[k-1];
            end
        end
    end
endmodule

// >>> bench/cre_engine_asserts.sv
// Purpose: port-level checks of the reflectometry engine
// Assumes: one clock domain, async active high reset
// Notes:   bound to cre_engine from the bench top file
`timescale 1ns/100ps
module cre_engine_asserts
    import cre_pkg::*;
(
    input wire logic                clock,          // clock
    input wire logic                reset,          // reset
    input wire logic                s_axi_awvalid,  // write address valid
    input wire logic                s_axi_awready,  // write address ready
    input wire logic                s_axi_wvalid,   // write data valid
    input wire logic                s_axi_wready,   // write data ready
    input wire logic                s_axi_bvalid,   // write response valid
    input wire logic                s_axi_arvalid,  // read address valid
    input wire logic                s_axi_arready,  // read address ready
    input wire logic                s_axi_rvalid,   // read data valid
    input wire logic                s_axi_rready,   // read data ready
    input wire logic [31:0]         s_axi_rdata,    // read data
    input wire logic                engine_active,  // engine owns drivers
    input wire cre_pkg::cre_drive_t drive           // driver controls
);
    // ==========================================================
    // fast pulse length and polarity history
    logic [3:0] hs_cnt_r;
    logic [3:0] hs_cnt_nxt;
    logic       seen_r;
    logic       seen_nxt;
    logic       neg_r;
    logic       neg_nxt;

    always_comb begin
        hs_cnt_nxt = drive.hs_drive ? hs_cnt_r + 4'h1 : 4'h0;
        seen_nxt   = seen_r;
        neg_nxt    = neg_r;
        if (drive.hs_drive && hs_cnt_r == 4'h0) begin
            seen_nxt = 1'b1;
            neg_nxt  = drive.hs_negative;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            hs_cnt_r <= 4'h0;
            seen_r   <= 1'b0;
            neg_r    <= 1'b0;
        end else begin
            hs_cnt_r <= hs_cnt_nxt;
            seen_r   <= seen_nxt;
            neg_r    <= neg_nxt;
        end
    end

    // ==========================================================
    // assertions
    default clocking @(posedge clock); endclocking
    default disable iff (reset);

    sequence s_slow_5;
        drive.ls_drive [*5];
    endsequence

    sequence s_fast_start;
        drive.hs_drive && hs_cnt_r == 4'h0;
    endsequence

    a_drive_needs_en: assert property ((drive.ls_drive || drive.hs_drive) |-> engine_active)
        else $error("pulse driven while engine disabled");
    a_one_driver: assert property (!(drive.ls_drive && drive.hs_drive))
        else $error("both line drivers pulsed");
    a_fast_width: assert property (drive.hs_drive |-> hs_cnt_r < 4'h7)
        else $error("fast pulse longer than seven units");
    a_fast_polarity: assert property (s_fast_start |-> drive.hs_negative == (seen_r && !neg_r))
        else $error("fast pulse polarity did not alternate");
    a_slow_width: assert property ($rose(drive.ls_drive) |->
        s_slow_5 ##1 (!drive.ls_drive or (s_slow_5 ##1 !drive.ls_drive)))
        else $error("slow pulse not 5 or 10 cycles");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write response late");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read data late");
    a_rdata_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data not held");
    a_rdata_upper: assert property (s_axi_rvalid |-> s_axi_rdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
endmodule

// >>> bench/cre_engine_bench.sv
// Purpose: register level runs of the reflectometry engine against a cable
// Assumes: echo at slot 20, crosstalk at slot 24
// Notes:   results are {slot, sample}
`timescale 1ns/100ps
module cre_engine_bench;
    import cre_pkg::*;
    localparam logic [7:0] A_CTL = {IDX_CONTROL, 2'b00};
    localparam logic [7:0] A_WIN = {IDX_WINDOW, 2'b00};
    localparam logic [7:0] A_PK  = {IDX_PEAK, 2'b00};
    localparam logic [7:0] A_TR  = {IDX_THRESH_RES, 2'b00};
    localparam logic [7:0] A_LVL = {IDX_THRESH_LVL, 2'b00};
    localparam logic [7:0] A_ST  = {IDX_STATUS, 2'b00};
    logic         clock, reset, awvalid, wvalid, bready, arvalid, rready;
    logic         awready, wready, bvalid, arready, rvalid, act;
    logic [7:0]   awaddr, araddr;
    logic [31:0]  wdata, rdata, d;
    logic [1:0]   bresp, rresp, r;
    cre_samples_t smp;
    cre_drive_t   drv;
    int           n_fail, n_tests;
    logic [15:0]  ctl [8] = '{16'hcb00, 16'hcb80, 16'h8900, 16'h9900, 16'hb900, 16'h8800, 16'h8c00, 16'h8900};
    logic [15:0]  win [8] = '{16'h0030, 16'h0030, 16'h0830, 16'h0030, 16'h0030, 16'h0030, 16'h1030, 16'h0830};
    logic [15:0]  epk [8] = '{16'h0064, 16'h009c, 16'h1432, 16'h1819, 16'h0064, 16'h0000, 16'h1432, 16'h1432};
    logic [15:0]  eth [8] = '{16'h0064, 16'h009c, 16'h0000, 16'h0000, 16'h0064, 16'h0000, 16'h0000, 16'h1432};

    cre_engine i_dut (.clock(clock), .reset(reset), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .samples(smp),
        .engine_active(act), .drive(drv));
    cre_cable_model i_cable (.clock(clock), .reset(reset), .drive(drv), .samples(smp));

    always #5 clock = ~clock;

    // ==========================================================
    // checking and bus tasks
    task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
        n_tests++;
        if (s !== e) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, e, s);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [15:0] v, input logic [1:0] er);
        bit aw, w;
        aw = 0;
        w  = 0;
        @(posedge clock);
        awaddr  <= a;
        wdata   <= {16'h0000, v};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        while (!(aw && w)) begin
            @(posedge clock);
            if (!aw && awready) begin
                aw = 1;
                awvalid <= 1'b0;
            end
            if (!w && wready) begin
                w = 1;
                wvalid <= 1'b0;
            end
        end
        do @(posedge clock); while (bvalid !== 1'b1);
        bready <= 1'b0;
        chk("bresp", {30'h0, bresp}, {30'h0, er});
    endtask

    task automatic rd(input logic [7:0] a, input bit slow = 1'b0);
        @(posedge clock);
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= !slow;
        do @(posedge clock); while (arready !== 1'b1);
        arvalid <= 1'b0;
        if (slow) begin
            @(posedge clock);
            rready <= 1'b1;
        end
        do @(posedge clock); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask

    task automatic rc(input string nm, input logic [7:0] a, input logic [15:0] e, input logic [1:0] er);
        rd(a);
        chk(nm, d, {16'h0000, e});
        chk("rresp", {30'h0, r}, {30'h0, er});
    endtask

    task automatic results;
        $display("comparisons %0d mismatches %0d", n_tests, n_fail);
        if (n_fail == 0 && n_tests > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clock = 0;
        reset = 1;
        {awvalid, wvalid, bready, arvalid, rready} = '0;
        {awaddr, araddr, wdata} = '0;
        repeat (12) @(posedge clock);
        reset <= 1'b0;
        rc("control", A_CTL, CTRL_RESET, RESP_OKAY);
        chk("active", {31'h0, act}, 32'h0);
        rc("window", A_WIN, 16'h00ff, RESP_OKAY);
        rc("peak", A_PK, 16'h0000, RESP_OKAY);
        rc("threshold", A_TR, 16'h0000, RESP_OKAY);
        rc("unmapped", 8'h00, 16'h0000, RESP_SLVERR);
        wr(8'h00, 16'h1234, RESP_SLVERR);
        wr(A_PK, 16'hffff, RESP_OKAY);
        rc("peak read only", A_PK, 16'h0000, RESP_OKAY);
        $display("test registers done");
        for (int i = 0; i < 8; i++) begin
            if (i == 7) begin
                wr(A_LVL, 16'h0020, RESP_OKAY);
            end
            wr(A_WIN, win[i], RESP_OKAY);
            wr(A_CTL, ctl[i], RESP_OKAY);
            do rd(A_ST, 1'b1); while (d[1] !== 1'b1);
            chk("active", {31'h0, act}, 32'h1);
            rc("peak", A_PK, epk[i], RESP_OKAY);
            rc("threshold", A_TR, eth[i], RESP_OKAY);
            rc("control", A_CTL, ctl[i] & 16'hf7ff, RESP_OKAY);
            rc("peak held", A_PK, epk[i], RESP_OKAY);
            $display("test run %0d done", i);
        end
        results;
    end

    initial begin
        repeat (40000) @(posedge clock);
        n_fail++;
        $display("watchdog expired");
        results;
    end
endmodule

bind cre_engine cre_engine_asserts u_chk (.clock(clock), .reset(reset), .s_axi_awvalid(s_axi_awvalid),
    .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .engine_active(engine_active), .drive(drive));

// >>> src/cre_engine.sv
// Purpose: cable reflectometry engine, pulse generator and monitor, AXI4-Lite slave
// Assumes: converter samples arrive one per clock, signed, synchronous
// Notes:   a run ends after the last window slot; results hold until next launch
//
// Register access over AXI4-Lite was chosen for this implementation.
`timescale 1ns/100ps
module cre_engine
    import cre_pkg::*;
(
    input  wire logic                       clock,          // 100 MHz clock
    input  wire logic                       reset,          // async reset, active high
    input  wire logic [cre_pkg::ADDR_W-1:0] s_axi_awaddr,   // write address
    input  wire logic                       s_axi_awvalid,  // write address valid
    output logic                            s_axi_awready,  // write address ready
    input  wire logic [31:0]                s_axi_wdata,    // write data
    input  wire logic [3:0]                 s_axi_wstrb,    // write byte enables
    input  wire logic                       s_axi_wvalid,   // write data valid
    output logic                            s_axi_wready,   // write data ready
    output logic [1:0]                      s_axi_bresp,    // write response
    output logic                            s_axi_bvalid,   // write response valid
    input  wire logic                       s_axi_bready,   // write response ready
    input  wire logic [cre_pkg::ADDR_W-1:0] s_axi_araddr,   // read address
    input  wire logic                       s_axi_arvalid,  // read address valid
    output logic                            s_axi_arready,  // read address ready
    output logic [31:0]                     s_axi_rdata,    // read data
    output logic [1:0]                      s_axi_rresp,    // read response
    output logic                            s_axi_rvalid,   // read data valid
    input  wire logic                       s_axi_rready,   // read data ready
    input  wire cre_pkg::cre_samples_t      samples,        // converter samples, both pairs
    output logic                            engine_active,  // drivers handed to engine
    output cre_pkg::cre_drive_t             drive           // line driver pulse controls
);
    import cre_pkg::*;

    // ==========================================================
    // helpers
    function automatic logic [5:0] reg_index(input logic [ADDR_W-1:0] addr);
        reg_index = addr[ADDR_W-1:2];
    endfunction

    function automatic logic [7:0] pulse_cycles(input logic fast, input logic [2:0] width);
        if (width == 3'h0) begin
            pulse_cycles = 8'h00;
        end else if (fast) begin
            pulse_cycles = (width > 3'(HS_MAX_UNITS)) ? 8'(HS_MAX_UNITS) : 8'(width);
        end else if (width >= 3'(LS_LONG_WIDTH)) begin
            pulse_cycles = 8'(LS_LONG_CYC);
        end else begin
            pulse_cycles = 8'(LS_SHORT_CYC);
        end
    endfunction

    // ==========================================================
    // bus handshake state
    logic                    aw_have_r, aw_have_nxt;
    logic                    w_have_r, w_have_nxt;
    logic [ADDR_W-1:0]       aw_addr_r, aw_addr_nxt;
    logic [31:0]             w_data_r, w_data_nxt;
    logic [3:0]              w_strb_r, w_strb_nxt;
    logic                    bvalid_r, bvalid_nxt;
    logic [1:0]              bresp_r, bresp_nxt;
    logic                    rvalid_r, rvalid_nxt;
    logic [1:0]              rresp_r, rresp_nxt;
    logic [31:0]             rdata_r, rdata_nxt;
    logic                    wr_fire;

    // ==========================================================
    // register and engine state
    logic [15:0]             control_r, control_nxt;
    logic [15:0]             window_r, window_nxt;
    logic [15:0]             thresh_lvl_r, thresh_lvl_nxt;
    logic [15:0]             peak_res_r, peak_res_nxt;
    logic [15:0]             thresh_res_r, thresh_res_nxt;
    cre_state_t              state_r, state_nxt;
    logic [7:0]              slot_r, slot_nxt;
    logic [7:0]              pulse_left_r, pulse_left_nxt;
    logic                    hs_neg_r, hs_neg_nxt;
    logic                    peak_seen_r, peak_seen_nxt;
    logic                    thr_seen_r, thr_seen_nxt;
    logic                    done_r, done_nxt;
    logic                    on_rx_r, on_rx_nxt;
    logic                    fast_run_r, fast_run_nxt;
    cre_drive_t              drive_r, drive_nxt;

    assign s_axi_awready = !aw_have_r && !bvalid_r;
    assign s_axi_wready  = !w_have_r && !bvalid_r;
    assign s_axi_arready = !rvalid_r;
    assign s_axi_bvalid  = bvalid_r;
    assign s_axi_bresp   = bresp_r;
    assign s_axi_rvalid  = rvalid_r;
    assign s_axi_rresp   = rresp_r;
    assign s_axi_rdata   = rdata_r;
    assign engine_active = control_r[CTRL_ENABLE];
    assign drive         = drive_r;
    assign wr_fire       = aw_have_r && w_have_r && !bvalid_r;

    // ==========================================================
    // bus handshake
    always_comb begin
        aw_have_nxt = aw_have_r;
        w_have_nxt  = w_have_r;
        aw_addr_nxt = aw_addr_r;
        w_data_nxt  = w_data_r;
        w_strb_nxt  = w_strb_r;
        bvalid_nxt  = bvalid_r;
        bresp_nxt   = bresp_r;
        rvalid_nxt  = rvalid_r;
        rresp_nxt   = rresp_r;
        rdata_nxt   = rdata_r;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_have_nxt = 1'b1;
            aw_addr_nxt = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_have_nxt = 1'b1;
            w_data_nxt = s_axi_wdata;
            w_strb_nxt = s_axi_wstrb;
        end
        if (wr_fire) begin
            aw_have_nxt = 1'b0;
            w_have_nxt  = 1'b0;
            bvalid_nxt  = 1'b1;
            unique case (reg_index(aw_addr_r))
                IDX_CONTROL, IDX_WINDOW, IDX_THRESH_LVL, IDX_PEAK, IDX_THRESH_RES, IDX_STATUS: begin
                    bresp_nxt = RESP_OKAY;
                end
                default: begin
                    bresp_nxt = RESP_SLVERR;
                end
            endcase
        end else if (bvalid_r && s_axi_bready) begin
            bvalid_nxt = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            rvalid_nxt = 1'b1;
            rresp_nxt  = RESP_OKAY;
            rdata_nxt  = 32'h0000_0000;
            unique case (reg_index(s_axi_araddr))
                IDX_CONTROL:    rdata_nxt[15:0] = control_r;
                IDX_WINDOW:     rdata_nxt[15:0] = window_r;
                IDX_PEAK:       rdata_nxt[15:0] = peak_res_r;
                IDX_THRESH_RES: rdata_nxt[15:0] = thresh_res_r;
                IDX_THRESH_LVL: rdata_nxt[15:0] = thresh_lvl_r;
                IDX_STATUS:     rdata_nxt[3:0]  = {peak_seen_r, thr_seen_r, done_r, state_r == CRE_RUN};
                default:        rresp_nxt       = RESP_SLVERR;
            endcase
        end else if (rvalid_r && s_axi_rready) begin
            rvalid_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            aw_have_r <= 1'b0;
            w_have_r  <= 1'b0;
            aw_addr_r <= '0;
            w_data_r  <= 32'h0000_0000;
            w_strb_r  <= 4'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= RESP_OKAY;
            rvalid_r  <= 1'b0;
            rresp_r   <= RESP_OKAY;
            rdata_r   <= 32'h0000_0000;
        end else begin
            aw_have_r <= aw_have_nxt;
            w_have_r  <= w_have_nxt;
            aw_addr_r <= aw_addr_nxt;
            w_data_r  <= w_data_nxt;
            w_strb_r  <= w_strb_nxt;
            bvalid_r  <= bvalid_nxt;
            bresp_r   <= bresp_nxt;
            rvalid_r  <= rvalid_nxt;
            rresp_r   <= rresp_nxt;
            rdata_r   <= rdata_nxt;
        end
    end

    // ==========================================================
    // registers, pulse generator and monitor
    logic [15:0]       wr_mask;
    logic [15:0]       ctrl_written;
    logic              launch;
    logic              in_window;
    logic              new_peak;
    logic              crossed;
    logic signed [7:0] sample;
    logic signed [7:0] peak_val;
    logic signed [7:0] thr_val;

    always_comb begin
        control_nxt    = control_r;
        window_nxt     = window_r;
        thresh_lvl_nxt = thresh_lvl_r;
        peak_res_nxt   = peak_res_r;
        thresh_res_nxt = thresh_res_r;
        state_nxt      = state_r;
        slot_nxt       = slot_r;
        pulse_left_nxt = pulse_left_r;
        hs_neg_nxt     = hs_neg_r;
        peak_seen_nxt  = peak_seen_r;
        thr_seen_nxt   = thr_seen_r;
        done_nxt       = done_r;
        on_rx_nxt      = on_rx_r;
        fast_run_nxt   = fast_run_r;
        wr_mask        = {{8{w_strb_r[1]}}, {8{w_strb_r[0]}}};
        ctrl_written   = (control_r & ~wr_mask) | (w_data_r[15:0] & wr_mask);
        launch         = 1'b0;
        peak_val       = $signed(peak_res_r[7:0]);
        thr_val        = $signed(thresh_lvl_r[7:0]);
        // pair under watch
        sample = control_r[CTRL_MON_RX] ? samples.rx_pair : samples.tx_pair;
        // window qualification of the current slot
        in_window = (slot_r >= window_r[WIN_FIRST_HI:WIN_FIRST_LO])
                 && (slot_r <= window_r[WIN_LAST_HI:WIN_LAST_LO]);
        if (control_r[CTRL_MIN_MODE]) begin
            new_peak = !peak_seen_r || (sample < peak_val);
            crossed  = sample < thr_val;
        end else begin
            new_peak = !peak_seen_r || (sample > peak_val);
            crossed  = sample > thr_val;
        end

        if (wr_fire) begin
            unique case (reg_index(aw_addr_r))
                IDX_CONTROL: begin
                    control_nxt = ctrl_written;
                    launch      = ctrl_written[CTRL_LAUNCH] && ctrl_written[CTRL_ENABLE];
                end
                IDX_WINDOW:     window_nxt     = (window_r & ~wr_mask) | (w_data_r[15:0] & wr_mask);
                IDX_THRESH_LVL: thresh_lvl_nxt = (thresh_lvl_r & ~wr_mask) | (w_data_r[15:0] & wr_mask);
                default: ;
            endcase
        end
        // launch bit is never stored and always reads back as zero
        control_nxt[CTRL_LAUNCH] = 1'b0;

        unique case (state_r)
            CRE_IDLE: begin
                pulse_left_nxt = 8'h00;
            end
            CRE_RUN: begin
                if (pulse_left_r != 8'h00) begin
                    pulse_left_nxt = pulse_left_r - 8'h01;
                end
                if (state_r == CRE_RUN && in_window) begin
                    if (new_peak) begin
                        peak_res_nxt  = {slot_r, sample};
                        peak_seen_nxt = 1'b1;
                    end
                    if (crossed && !thr_seen_r) begin
                        thresh_res_nxt = {slot_r, sample};
                        thr_seen_nxt   = 1'b1;
                    end
                end
                if (slot_r == window_r[WIN_LAST_HI:WIN_LAST_LO]) begin
                    state_nxt      = CRE_IDLE;
                    done_nxt       = 1'b1;
                    pulse_left_nxt = 8'h00;
                end else begin
                    slot_nxt = slot_r + 8'h01;
                end
            end
        endcase

        if (launch) begin
            state_nxt      = CRE_RUN;
            slot_nxt       = 8'h00;
            done_nxt       = 1'b0;
            peak_seen_nxt  = 1'b0;
            thr_seen_nxt   = 1'b0;
            peak_res_nxt   = RESULT_RESET;
            thresh_res_nxt = RESULT_RESET;
            fast_run_nxt   = ctrl_written[CTRL_FAST];
            on_rx_nxt      = ctrl_written[CTRL_TX_RX];
            pulse_left_nxt = pulse_cycles(ctrl_written[CTRL_FAST],
                                          ctrl_written[CTRL_WIDTH_HI:CTRL_WIDTH_LO]);
            if (state_r == CRE_RUN && fast_run_r && drive_r.hs_drive) begin
                hs_neg_nxt = !hs_neg_r;
            end
        end else if (state_r == CRE_RUN && pulse_left_r == 8'h01 && fast_run_r) begin
            hs_neg_nxt = !hs_neg_r;
        end

        if (!control_nxt[CTRL_ENABLE]) begin
            state_nxt      = CRE_IDLE;
            pulse_left_nxt = 8'h00;
        end

        drive_nxt.ls_drive    = (pulse_left_nxt != 8'h00) && !fast_run_nxt;
        drive_nxt.hs_drive    = (pulse_left_nxt != 8'h00) && fast_run_nxt;
        drive_nxt.hs_negative = hs_neg_nxt;
        drive_nxt.on_rx_pair  = on_rx_nxt;
    end

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            control_r    <= CTRL_RESET;
            window_r     <= WIN_RESET;
            thresh_lvl_r <= THRESH_RESET;
            peak_res_r   <= RESULT_RESET;
            thresh_res_r <= RESULT_RESET;
            state_r      <= CRE_IDLE;
            slot_r       <= 8'h00;
            pulse_left_r <= 8'h00;
            hs_neg_r     <= 1'b0;
            peak_seen_r  <= 1'b0;
            thr_seen_r   <= 1'b0;
            done_r       <= 1'b0;
            on_rx_r      <= 1'b0;
            fast_run_r   <= 1'b0;
            drive_r      <= '0;
        end else begin
            control_r    <= control_nxt;
            window_r     <= window_nxt;
            thresh_lvl_r <= thresh_lvl_nxt;
            peak_res_r   <= peak_res_nxt;
            thresh_res_r <= thresh_res_nxt;
            state_r      <= state_nxt;
            slot_r       <= slot_nxt;
            pulse_left_r <= pulse_left_nxt;
            hs_neg_r     <= hs_neg_nxt;
            peak_seen_r  <= peak_seen_nxt;
            thr_seen_r   <= thr_seen_nxt;
            done_r       <= done_nxt;
            on_rx_r      <= on_rx_nxt;
            fast_run_r   <= fast_run_nxt;
            drive_r      <= drive_nxt;
        end
    end

endmodule

// >>> src/cre_pkg.sv
// Purpose: shared constants and types of the cable reflectometry engine
// Assumes: one slot per clock; 16-bit registers on a 32-bit bus
// Notes:   register byte address is four times the register index
package cre_pkg;

    // ==========================================================
    // timing
    localparam int CLK_PERIOD_NS = 10;
    localparam int LS_SHORT_NS   = 50;
    localparam int LS_LONG_NS    = 100;
    localparam int HS_UNIT_NS    = 8;
    localparam int HS_MAX_NS     = 56;
    localparam int SLOT_NS       = 8;
    localparam int WINDOW_MAX_NS = 2048;
    localparam int LS_SHORT_CYC  = (LS_SHORT_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int LS_LONG_CYC   = (LS_LONG_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int HS_MAX_UNITS  = HS_MAX_NS / HS_UNIT_NS;
    localparam int SLOT_COUNT    = WINDOW_MAX_NS / SLOT_NS;

    // ==========================================================
    // register indices and bus addressing
    localparam int         ADDR_W         = 8;
    localparam logic [5:0] IDX_CONTROL    = 6'h16;
    localparam logic [5:0] IDX_WINDOW     = 6'h17;
    localparam logic [5:0] IDX_PEAK       = 6'h18;
    localparam logic [5:0] IDX_THRESH_RES = 6'h19;
    localparam logic [5:0] IDX_THRESH_LVL = 6'h1c;
    localparam logic [5:0] IDX_STATUS     = 6'h1f;
    localparam logic [1:0] RESP_OKAY      = 2'h0;
    localparam logic [1:0] RESP_SLVERR    = 2'h2;

    // ==========================================================
    // control and window field positions
    localparam int CTRL_ENABLE   = 15;
    localparam int CTRL_FAST     = 14;
    localparam int CTRL_TX_RX    = 13;
    localparam int CTRL_MON_RX   = 12;
    localparam int CTRL_LAUNCH   = 11;
    localparam int CTRL_WIDTH_HI = 10;
    localparam int CTRL_WIDTH_LO = 8;
    localparam int CTRL_MIN_MODE = 7;
    localparam int WIN_FIRST_HI  = 15;
    localparam int WIN_FIRST_LO  = 8;
    localparam int WIN_LAST_HI   = 7;
    localparam int WIN_LAST_LO   = 0;
    localparam int LS_LONG_WIDTH = 4;

    // ==========================================================
    // reset values
    localparam logic [15:0] CTRL_RESET   = 16'h0000;
    localparam logic [15:0] WIN_RESET    = 16'h00ff;
    localparam logic [15:0] THRESH_RESET = 16'h0040;
    localparam logic [15:0] RESULT_RESET = 16'h0000;

    // ==========================================================
    // types
    typedef enum logic {CRE_IDLE, CRE_RUN} cre_state_t;

    typedef struct packed {
        logic ls_drive;   // low_speed_line_driver pulse on
        logic hs_drive;   // high_speed_line_driver pulse on
        logic hs_negative;
        logic on_rx_pair;
    } cre_drive_t;

    typedef struct packed {
        logic signed [7:0] tx_pair;
        logic signed [7:0] rx_pair;
    } cre_samples_t;

endpackage
